// ### src/tas_pkg.sv
// tas_pkg: register map, field layout, codes and carriers for the transmitter status and threshold block
package tas_pkg;

    // register numbers on the command interface
    localparam logic [7:0] REG_STATUS_F = 8'h20;
    localparam logic [7:0] REG_STATUS_W = 8'h21;
    localparam logic [7:0] REG_POW_F = 8'h22;
    localparam logic [7:0] REG_POW_W = 8'h23;
    localparam logic [7:0] REG_FREQ_F = 8'h24;
    localparam logic [7:0] REG_FREQ_W = 8'h25;
    localparam logic [7:0] REG_MOD_RESET = 8'h32;

    // status word fields
    localparam int BIT_XEL = 7;
    localparam int BIT_CEL = 6;
    localparam int BIT_MRL = 5;
    localparam int BIT_CRL = 4;
    localparam int BIT_NOW_LO = 8;
    localparam int BIT_TOP_LO = 12;

    // reset values of the event latches and threshold defaults
    localparam logic MRL_RESET = 1'b1;
    localparam logic CRL_RESET = 1'b1;
    localparam logic [15:0] POW_F_DEF = 16'h012c;
    localparam logic [15:0] POW_W_DEF = 16'h00c8;
    localparam logic [15:0] FREQ_F_DEF = 16'h0032;
    localparam logic [15:0] FREQ_W_DEF = 16'h0019;
    localparam logic [15:0] POW_MAX_DEF = 16'h07d0;
    localparam logic [15:0] FREQ_MAX_DEF = 16'h03e8;

    // packet timeout, as a time and as clock cycles at 100 MHz
    localparam int CLK_PERIOD_NS = 10;
    localparam int PKT_TIMEOUT_US = 200;
    localparam int PKT_TIMEOUT_CYC = PKT_TIMEOUT_US * 1000 / CLK_PERIOD_NS;

    // error condition codes returned in a response
    typedef enum logic [2:0] {
        ERR_OK = 3'b000,
        ERR_READ_ONLY = 3'b001,
        ERR_RANGE = 3'b010,
        ERR_IN_PROGRESS = 3'b011,
        ERR_INVALID = 3'b100,
        ERR_EXEC = 3'b101,
        ERR_VENDOR = 3'b110
    } tas_err_t;

    // register request from the command framing
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [15:0] data;
    } tas_req_t;

    // response to one request
    typedef struct packed {
        logic xe;
        tas_err_t err;
        logic [15:0] data;
    } tas_rsp_t;

    // measured deviations and condition inputs
    typedef struct packed {
        logic [15:0] power_dev;
        logic [15:0] freq_dev;
        logic [15:0] ageing;
        logic [15:0] ageing_fatal_threshold;
        logic [15:0] ageing_warning_threshold;
        logic fatal_thermal;
        logic warning_thermal;
        logic fatal_vendor;
        logic warning_vendor;
    } tas_cond_t;

    // the four threshold registers
    typedef struct packed {
        logic [15:0] power_fatal_threshold;
        logic [15:0] power_warning_threshold;
        logic [15:0] frequency_fatal_threshold;
        logic [15:0] frequency_warning_threshold;
    } tas_thr_t;

endpackage

// ### src/tas_sticky.sv
// tas_sticky: one latched flag, set by hardware, cleared by the host, set winning
`timescale 1ns/1ps
module tas_sticky #(
    parameter logic RESET_VAL = 1'b0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // set and clear
    input wire logic set,
    input wire logic clr,
    // flag
    output logic q
);

    logic q_r;
    logic q_nxt;

    // a set in the clearing cycle keeps the flag up
    always_comb
    begin
        q_nxt = set | (q_r & ~clr);
    end

    // register the flag
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            q_r <= RESET_VAL;
        else if (ce)
            q_r <= q_nxt;
    end

    assign q = q_r;

endmodule // tas_sticky

// ### src/tas_status_thresholds.sv
// tas_status_thresholds: fatal and warning status words and power and frequency thresholds
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - bit 11 of each status word follows the fatal or warning vendor fault.
// - ageing above its fatal or warning threshold also raises bit 11.
// - bit 10 is high while frequency deviation exceeds its threshold.
// - bit 9 follows the fatal or warning thermal condition input.
// - bit 8 is high while power deviation exceeds its threshold.
// - bit 7 latches failed immediate commands and failed pending operations.
// - in RS232 mode only failed pending operations set bit 7.
// - bit 6 latches communication errors until the host clears it.
// - bit 5 is one after reset and on every restart until cleared.
// - a write to the module reset register restarts the module and sets bit 5.
// - bit 4 is one after reset and on every interface reset, which flushes buffers.
// - a packet left incomplete past the timeout resets the interface.
// - bits 3 to 0 are sticky copies of bits 11 to 8.
// - writing one clears a latched bit; writing zero leaves it.
// - power thresholds are unsigned 16 bit; out of range writes give execution error.
// - frequency thresholds are unsigned 16 bit and drive the frequency comparisons.
// - thresholds keep a default that a stored configuration may replace.
// - good threshold writes act at once and answer OK with the value.
// - failed accesses answer execution error, a code, data zero, and set error field.
// - a latched condition still present after a clear sets its bit again.
// - bits 15 to 8 show current conditions and ignore writes silently.
module tas_status_thresholds #(
    parameter int TIMEOUT_CYC = tas_pkg::PKT_TIMEOUT_CYC,
    parameter logic [15:0] POW_MAX = tas_pkg::POW_MAX_DEF,
    parameter logic [15:0] FREQ_MAX = tas_pkg::FREQ_MAX_DEF
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    // register requests and responses
    input wire logic cmd_valid,
    input wire tas_pkg::tas_req_t cmd,
    input wire logic cmd_busy,
    output logic rsp_valid,
    output tas_pkg::tas_rsp_t rsp,
    output tas_pkg::tas_err_t error_field,
    // conditions
    input wire tas_pkg::tas_cond_t cond,
    input wire logic [3:0] fatal_top_now,
    input wire logic [3:0] warning_top_now,
    // events
    input wire logic immediate_fail,
    input wire logic pending_fail,
    input wire logic rs232_mode,
    input wire logic comm_error,
    input wire logic restart_event,
    input wire logic comm_reset_event,
    input wire logic packet_open,
    input wire logic packet_byte,
    // stored configuration
    input wire logic nv_load,
    input wire tas_pkg::tas_thr_t nv_thr,
    // results
    output logic [15:0] fatal_status_word,
    output logic [15:0] warning_status_word,
    output tas_pkg::tas_thr_t thresholds,
    output logic module_restart_req,
    output logic comm_flush
);

    localparam int CW = $clog2(TIMEOUT_CYC + 1);

    ////////////////////////////////////////////////////////////////////////////
    // current conditions
    logic [3:0] fatal_now;
    logic [3:0] warning_now;
    logic [3:0] fatal_latch;
    logic [3:0] warning_latch;
    logic execution_error_latch;
    logic comm_error_latch;
    logic restart_latch;
    logic comm_reset_latch;
    tas_pkg::tas_thr_t thr_r;
    tas_pkg::tas_thr_t thr_nxt;

    // order within each nibble: vendor, frequency, thermal, power
    always_comb
    begin
        fatal_now[3] = cond.fatal_vendor | (cond.ageing > cond.ageing_fatal_threshold);
        warning_now[3] = cond.warning_vendor | (cond.ageing > cond.ageing_warning_threshold);
        fatal_now[2] = cond.freq_dev > thr_r.frequency_fatal_threshold;
        warning_now[2] = cond.freq_dev > thr_r.frequency_warning_threshold;
        fatal_now[1] = cond.fatal_thermal;
        warning_now[1] = cond.warning_thermal;
        fatal_now[0] = cond.power_dev > thr_r.power_fatal_threshold;
        warning_now[0] = cond.power_dev > thr_r.power_warning_threshold;
    end

    ////////////////////////////////////////////////////////////////////////////
    // request decode
    logic wr_f;
    logic wr_w;
    logic ok_wr;
    logic [15:0] clr_mask;
    logic [15:0] status_f;
    logic [15:0] status_w;

    // a successful write to either status word carries a clear mask
    assign wr_f = cmd_valid & cmd.wr & ~cmd_busy & (cmd.addr == tas_pkg::REG_STATUS_F);
    assign wr_w = cmd_valid & cmd.wr & ~cmd_busy & (cmd.addr == tas_pkg::REG_STATUS_W);
    assign ok_wr = wr_f | wr_w;
    assign clr_mask = ok_wr ? cmd.data : 16'h0000; // upper byte ignored

    ////////////////////////////////////////////////////////////////////////////
    // latched deviation flags, one cell per bit
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_dev
            tas_sticky #(.RESET_VAL(1'b0)) u_f (
                .clk_sys(clk_sys),
                .rst(rst),
                .ce(ce),
                .set(fatal_now[gi]),
                .clr(wr_f & cmd.data[gi]),
                .q(fatal_latch[gi])
            );
            tas_sticky #(.RESET_VAL(1'b0)) u_w (
                .clk_sys(clk_sys),
                .rst(rst),
                .ce(ce),
                .set(warning_now[gi]),
                .clr(wr_w & cmd.data[gi]),
                .q(warning_latch[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // event latches shared by both words
    logic xel_set;
    logic mrl_set;
    logic crl_set;
    logic reset_wr;
    logic timeout_hit;

    assign xel_set = pending_fail | (immediate_fail & ~rs232_mode);
    assign reset_wr = cmd_valid & cmd.wr & ~cmd_busy & (cmd.addr == tas_pkg::REG_MOD_RESET);
    assign mrl_set = restart_event | reset_wr;
    assign crl_set = comm_reset_event | timeout_hit;

    tas_sticky #(.RESET_VAL(1'b0)) u_xel (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .set(xel_set),
        .clr(clr_mask[tas_pkg::BIT_XEL]),
        .q(execution_error_latch)
    );
    tas_sticky #(.RESET_VAL(1'b0)) u_cel (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .set(comm_error),
        .clr(clr_mask[tas_pkg::BIT_CEL]),
        .q(comm_error_latch)
    );
    tas_sticky #(.RESET_VAL(tas_pkg::MRL_RESET)) u_mrl (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .set(mrl_set),
        .clr(clr_mask[tas_pkg::BIT_MRL]),
        .q(restart_latch)
    );
    tas_sticky #(.RESET_VAL(tas_pkg::CRL_RESET)) u_crl (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .set(crl_set),
        .clr(clr_mask[tas_pkg::BIT_CRL]),
        .q(comm_reset_latch)
    );

    // assemble the two words
    assign status_f = {fatal_top_now, fatal_now, execution_error_latch, comm_error_latch,
                       restart_latch, comm_reset_latch, fatal_latch};
    assign status_w = {warning_top_now, warning_now, execution_error_latch, comm_error_latch,
                       restart_latch, comm_reset_latch, warning_latch};
    assign fatal_status_word = status_f;
    assign warning_status_word = status_w;

    ////////////////////////////////////////////////////////////////////////////
    // packet timeout counter
    logic [CW-1:0] to_cnt_r;
    logic [CW-1:0] to_cnt_nxt;
    logic flush_r;
    logic flush_nxt;

    // counts idle cycles inside an open packet; a byte restarts it
    always_comb
    begin
        timeout_hit = packet_open & (to_cnt_r == CW'(TIMEOUT_CYC - 1));
        if (!packet_open || packet_byte || timeout_hit)
            to_cnt_nxt = '0;
        else
            to_cnt_nxt = to_cnt_r + CW'(1);
        flush_nxt = crl_set; // interface reset flushes input buffers
    end

    // register counter and flush strobe
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            to_cnt_r <= '0;
            flush_r <= 1'b0;
        end
        else if (ce)
        begin
            to_cnt_r <= to_cnt_nxt;
            flush_r <= flush_nxt;
        end
    end

    assign comm_flush = flush_r;

    ////////////////////////////////////////////////////////////////////////////
    // thresholds and responses
    logic rsp_valid_r;
    logic rsp_valid_nxt;
    tas_pkg::tas_rsp_t rsp_r;
    tas_pkg::tas_rsp_t rsp_nxt;
    tas_pkg::tas_err_t err_r;
    tas_pkg::tas_err_t err_nxt;
    logic restart_r;
    logic restart_nxt;
    logic [15:0] rd_data;
    logic is_thr;
    logic is_pow;
    logic in_range;
    tas_pkg::tas_err_t code;

    // decode one request, answer on the next cycle
    always_comb
    begin
        thr_nxt = nv_load ? nv_thr : thr_r; // stored configuration replaces defaults
        rsp_valid_nxt = cmd_valid;
        restart_nxt = reset_wr;
        err_nxt = err_r;
        is_pow = (cmd.addr == tas_pkg::REG_POW_F) || (cmd.addr == tas_pkg::REG_POW_W);
        is_thr = is_pow || (cmd.addr == tas_pkg::REG_FREQ_F) || (cmd.addr == tas_pkg::REG_FREQ_W);
        in_range = is_pow ? (cmd.data <= POW_MAX) : (cmd.data <= FREQ_MAX);
        rd_data = 16'h0000;
        code = tas_pkg::ERR_OK;
        unique case (cmd.addr)
            tas_pkg::REG_STATUS_F: rd_data = status_f;
            tas_pkg::REG_STATUS_W: rd_data = status_w;
            tas_pkg::REG_POW_F: rd_data = thr_r.power_fatal_threshold;
            tas_pkg::REG_POW_W: rd_data = thr_r.power_warning_threshold;
            tas_pkg::REG_FREQ_F: rd_data = thr_r.frequency_fatal_threshold;
            tas_pkg::REG_FREQ_W: rd_data = thr_r.frequency_warning_threshold;
            tas_pkg::REG_MOD_RESET: rd_data = 16'h0000;
            default: code = tas_pkg::ERR_INVALID;
        endcase
        if (cmd_busy)
            code = tas_pkg::ERR_IN_PROGRESS;
        else if (cmd.wr && is_thr && !in_range)
            code = tas_pkg::ERR_RANGE;
        if (cmd_valid && cmd.wr && is_thr && code == tas_pkg::ERR_OK)
        begin
            unique case (cmd.addr)
                tas_pkg::REG_POW_F: thr_nxt.power_fatal_threshold = cmd.data;
                tas_pkg::REG_POW_W: thr_nxt.power_warning_threshold = cmd.data;
                tas_pkg::REG_FREQ_F: thr_nxt.frequency_fatal_threshold = cmd.data;
                default: thr_nxt.frequency_warning_threshold = cmd.data;
            endcase
        end
        if (code != tas_pkg::ERR_OK)
        begin
            rsp_nxt = '{xe: 1'b1, err: code, data: 16'h0000};
            if (cmd_valid)
                err_nxt = code;
        end
        else if (cmd.wr)
            rsp_nxt = '{xe: 1'b0, err: tas_pkg::ERR_OK, data: cmd.data}; // echo written value
        else
            rsp_nxt = '{xe: 1'b0, err: tas_pkg::ERR_OK, data: rd_data};
        if (!cmd_valid)
            rsp_nxt = rsp_r;
    end

    // register thresholds, response and restart strobe
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            thr_r <= '{tas_pkg::POW_F_DEF, tas_pkg::POW_W_DEF, tas_pkg::FREQ_F_DEF, tas_pkg::FREQ_W_DEF};
            rsp_valid_r <= 1'b0;
            rsp_r <= '{xe: 1'b0, err: tas_pkg::ERR_OK, data: 16'h0000};
            err_r <= tas_pkg::ERR_OK;
            restart_r <= 1'b0;
        end
        else if (ce)
        begin
            thr_r <= thr_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_r <= rsp_nxt;
            err_r <= err_nxt;
            restart_r <= restart_nxt;
        end
    end

    assign rsp_valid = rsp_valid_r;
    assign rsp = rsp_r;
    assign error_field = err_r;
    assign thresholds = thr_r;
    assign module_restart_req = restart_r;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence s_good_thr_wr;
        ce && cmd_valid && cmd.wr && !cmd_busy && cmd.addr == tas_pkg::REG_POW_F && cmd.data <= POW_MAX;
    endsequence

    sequence s_clear_f0;
        ce && wr_f && cmd.data[0] && !fatal_now[0];
    endsequence

    vendor_bit_a: assert property (fatal_status_word[11] == (cond.fatal_vendor || cond.ageing > cond.ageing_fatal_threshold))
        else $error("fatal vendor bit wrong");
    freq_bit_a: assert property (warning_status_word[10] == (cond.freq_dev > thr_r.frequency_warning_threshold))
        else $error("warning frequency bit wrong");
    therm_pwr_a: assert property (fatal_status_word[9:8] == {cond.fatal_thermal, cond.power_dev > thr_r.power_fatal_threshold})
        else $error("thermal or power bit wrong");
    xel_set_a: assert property (ce && pending_fail |=> fatal_status_word[7] && warning_status_word[7])
        else $error("execution latch missed");
    rs232_imm_a: assert property (ce && rs232_mode && immediate_fail && !pending_fail && !execution_error_latch |=> !execution_error_latch)
        else $error("immediate failure latched in rs232 mode");
    sticky_keep_a: assert property (ce && warning_now[2] |=> warning_status_word[2])
        else $error("latched deviation lost");
    clear_one_a: assert property (s_clear_f0 |=> !fatal_status_word[0])
        else $error("latched bit not cleared");
    thr_write_a: assert property (s_good_thr_wr |=> rsp_valid && !rsp.xe && thr_r.power_fatal_threshold == rsp.data)
        else $error("threshold write did not take effect");
    err_zero_a: assert property (rsp_valid && rsp.xe |-> rsp.data == 16'h0000 && error_field == rsp.err)
        else $error("error response carries data");
    restart_a: assert property (ce && reset_wr |=> module_restart_req && restart_latch)
        else $error("restart not reported");
    flush_a: assert property (ce && timeout_hit |=> comm_flush && comm_reset_latch)
        else $error("timeout did not reset interface");

endmodule // tas_status_thresholds

// ### test/tas_host_model.sv
// tas_host_model: host controller that issues register requests and collects responses
`timescale 1ns/1ps
module tas_host_model (
    // clock
    clk_sys,
    // request side
    cmd_valid,
    cmd,
    // response side
    rsp_valid,
    rsp
);
    input wire logic clk_sys;
    output logic cmd_valid = 1'b0;
    output tas_pkg::tas_req_t cmd = '0;
    input wire logic rsp_valid;
    input wire tas_pkg::tas_rsp_t rsp;
    bit timed_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // one request held for one edge, answer taken when rsp_valid is seen
    // host writes the reset register and writes ones to clear latches
    // warning power threshold kept at or below the fatal one by the callers
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [15:0] data,
                        output tas_pkg::tas_rsp_t got);
        int i;
        i = 0;
        got = '0;
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd <= '{wr: wr, addr: addr, data: data};
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        cmd <= ~{wr, addr, data}; // released: stale value never looks like the last request
        #1;
        while (i < 4 && rsp_valid !== 1'b1)
        begin
            @(posedge clk_sys);
            #1;
            i++;
        end
        timed_out = (rsp_valid !== 1'b1);
        got = rsp;
    endtask
endmodule // tas_host_model

// ### test/tas_status_thresholds_tb_top.sv
// tas_status_thresholds_tb_top: self-checking bench for the status and threshold block
`timescale 1ns/1ps
module tas_status_thresholds_tb_top;
    // stimulus
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic cmd_busy = 1'b0;
    logic rs232_mode = 1'b0;
    logic packet_open = 1'b0;
    logic packet_byte = 1'b0;
    logic nv_load = 1'b0;
    logic [4:0] ev = 5'h00;
    logic [3:0] ftop = 4'h0;
    logic [3:0] wtop = 4'h0;
    tas_pkg::tas_cond_t cond = '0;
    tas_pkg::tas_thr_t nv_thr = '0;
    // observed
    logic cmd_valid, rsp_valid, module_restart_req, comm_flush;
    tas_pkg::tas_req_t cmd;
    tas_pkg::tas_rsp_t rsp;
    tas_pkg::tas_rsp_t got;
    tas_pkg::tas_err_t error_field;
    tas_pkg::tas_thr_t thresholds;
    logic [15:0] fatal_status_word, warning_status_word;
    int err_total = 0;
    int n_compared = 0;
    int n_flush = 0;
    int n_rreq = 0;
    localparam tas_pkg::tas_thr_t THR_DEF = {tas_pkg::POW_F_DEF, tas_pkg::POW_W_DEF,
                                             tas_pkg::FREQ_F_DEF, tas_pkg::FREQ_W_DEF};
    typedef struct {logic wr; logic [7:0] addr; logic [15:0] data; tas_pkg::tas_rsp_t exp;} tas_row_t;
    tas_row_t rows[12] = '{
        '{1'b1, 8'h22, 16'h07d0, '{1'b0, tas_pkg::ERR_OK, 16'h07d0}},
        '{1'b1, 8'h22, 16'h07d1, '{1'b1, tas_pkg::ERR_RANGE, 16'h0000}},
        '{1'b0, 8'h22, 16'h0000, '{1'b0, tas_pkg::ERR_OK, 16'h07d0}},
        '{1'b1, 8'h23, 16'h0100, '{1'b0, tas_pkg::ERR_OK, 16'h0100}},
        '{1'b1, 8'h22, 16'h0200, '{1'b0, tas_pkg::ERR_OK, 16'h0200}},
        '{1'b0, 8'h23, 16'h0000, '{1'b0, tas_pkg::ERR_OK, 16'h0100}},
        '{1'b1, 8'h24, 16'h03e9, '{1'b1, tas_pkg::ERR_RANGE, 16'h0000}},
        '{1'b1, 8'h25, 16'h0010, '{1'b0, tas_pkg::ERR_OK, 16'h0010}},
        '{1'b0, 8'h24, 16'h0000, '{1'b0, tas_pkg::ERR_OK, 16'h0032}},
        '{1'b0, 8'h41, 16'h0000, '{1'b1, tas_pkg::ERR_INVALID, 16'h0000}},
        '{1'b1, 8'h41, 16'h1234, '{1'b1, tas_pkg::ERR_INVALID, 16'h0000}},
        '{1'b0, 8'h32, 16'h0000, '{1'b0, tas_pkg::ERR_OK, 16'h0000}}};

    ////////////////////////////////////////////////////////////////////////////////
    // design and host
    tas_status_thresholds #(.TIMEOUT_CYC(8)) DUT (.clk_sys(clk_sys), .rst(rst), .ce(ce),
        .cmd_valid(cmd_valid), .cmd(cmd), .cmd_busy(cmd_busy), .rsp_valid(rsp_valid), .rsp(rsp),
        .error_field(error_field), .cond(cond), .fatal_top_now(ftop), .warning_top_now(wtop),
        .immediate_fail(ev[0]), .pending_fail(ev[1]), .rs232_mode(rs232_mode), .comm_error(ev[2]),
        .restart_event(ev[3]), .comm_reset_event(ev[4]), .packet_open(packet_open),
        .packet_byte(packet_byte), .nv_load(nv_load), .nv_thr(nv_thr),
        .fatal_status_word(fatal_status_word), .warning_status_word(warning_status_word),
        .thresholds(thresholds), .module_restart_req(module_restart_req), .comm_flush(comm_flush));
    tas_host_model HOST (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd(cmd), .rsp_valid(rsp_valid),
        .rsp(rsp));

    // clock and pulse counters
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        n_flush += (comm_flush === 1'b1);
        n_rreq += (module_restart_req === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checking helpers
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_rsp(input tas_pkg::tas_rsp_t e, input tas_pkg::tas_rsp_t g);
        n_compared++;
        if (g !== e)
        begin
            err_total++;
            $display("BAD response expected %h seen %h", e, g);
        end
    endtask
    task automatic chk_thr(input tas_pkg::tas_thr_t e);
        for (int k = 0; k < 4; k++)
            chk16("thresholds", e[k*16+:16], thresholds[k*16+:16]);
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic acc(input logic wr, input logic [7:0] a, input logic [15:0] d);
        HOST.xfer(wr, a, d, got);
        if (HOST.timed_out)
        begin
            err_total++;
            summarize();
        end
    endtask
    task automatic words(input logic [15:0] ef, input logic [15:0] ew);
        chk16("fatal word", ef, fatal_status_word);
        chk16("warning word", ew, warning_status_word);
    endtask
    task automatic clr_all();
        acc(1'b1, 8'h20, 16'h00ff);
        acc(1'b1, 8'h21, 16'h00ff);
        step(1);
    endtask
    // condition held, cleared while present, then removed and cleared
    task automatic cond_case(input tas_pkg::tas_cond_t c, input logic [15:0] ef, input logic [15:0] ew);
        @(posedge clk_sys);
        cond <= c;
        step(2);
        words(ef, ew);
        clr_all();
        words(ef, ew);
        @(posedge clk_sys);
        cond <= '0;
        step(2);
        words(ef & 16'h00ff, ew & 16'h00ff);
        clr_all();
        words(16'h0000, 16'h0000);
    endtask
    // one event pulse, both words show the shared latch
    task automatic ev_case(input int idx, input logic rs, input logic [15:0] e);
        @(posedge clk_sys);
        rs232_mode <= rs;
        ev <= 5'h01 << idx;
        @(posedge clk_sys);
        ev <= 5'h00;
        step(2);
        words(e, e);
        clr_all();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        ftop <= 4'h5;
        wtop <= 4'ha;
        step(1);
        words(16'h5030, 16'ha030);
        chk_thr(THR_DEF);
        chk16("error field", 16'h0000, 16'(error_field));
        @(posedge clk_sys);
        ftop <= 4'h0;
        wtop <= 4'h0;
        clr_all();
        words(16'h0000, 16'h0000);
        acc(1'b1, 8'h20, 16'hff00);
        chk16("write ignored", 16'h0000, 16'({got.xe, got.err}));
        for (int r = 0; r < 12; r++)
        begin
            acc(rows[r].wr, rows[r].addr, rows[r].data);
            chk_rsp(rows[r].exp, got);
            if (rows[r].exp.xe === 1'b1)
                chk16("error field", 16'(rows[r].exp.err), 16'(error_field));
        end
        cond_case('{power_dev: 16'h0100, default: '0}, 16'h0000, 16'h0000);
        cond_case('{power_dev: 16'h0101, default: '0}, 16'h0000, 16'h0101);
        cond_case('{power_dev: 16'h0201, default: '0}, 16'h0101, 16'h0101);
        cond_case('{freq_dev: 16'h0020, default: '0}, 16'h0000, 16'h0404);
        cond_case('{freq_dev: 16'h0033, default: '0}, 16'h0404, 16'h0404);
        cond_case('{fatal_thermal: 1'b1, default: '0}, 16'h0202, 16'h0000);
        cond_case('{warning_thermal: 1'b1, default: '0}, 16'h0000, 16'h0202);
        cond_case('{fatal_vendor: 1'b1, default: '0}, 16'h0808, 16'h0000);
        cond_case('{warning_vendor: 1'b1, default: '0}, 16'h0000, 16'h0808);
        cond_case('{ageing: 16'h0100, ageing_fatal_threshold: 16'h0200, ageing_warning_threshold: 16'h00f0,
                    default: '0}, 16'h0000, 16'h0808);
        ev_case(0, 1'b0, 16'h0080);
        ev_case(0, 1'b1, 16'h0000);
        ev_case(1, 1'b1, 16'h0080);
        ev_case(2, 1'b0, 16'h0040);
        ev_case(3, 1'b0, 16'h0020);
        ev_case(4, 1'b0, 16'h0010);
        chk16("flush count", 16'd1, 16'(n_flush));
        acc(1'b1, 8'h32, 16'h0001);
        step(2);
        chk16("restart count", 16'd1, 16'(n_rreq));
        words(16'h0020, 16'h0020);
        clr_all();
        @(posedge clk_sys);
        cmd_busy <= 1'b1;
        acc(1'b1, 8'h22, 16'h0100);
        chk_rsp('{1'b1, tas_pkg::ERR_IN_PROGRESS, 16'h0000}, got);
        chk16("error field", 16'(tas_pkg::ERR_IN_PROGRESS), 16'(error_field));
        @(posedge clk_sys);
        cmd_busy <= 1'b0;
        acc(1'b0, 8'h22, 16'h0000);
        chk_rsp('{1'b0, tas_pkg::ERR_OK, 16'h0200}, got);
        @(posedge clk_sys);
        packet_open <= 1'b1;
        repeat (5)
        begin
            repeat (4) @(posedge clk_sys);
            packet_byte <= 1'b1;
            @(posedge clk_sys);
            packet_byte <= 1'b0;
        end
        packet_open <= 1'b0;
        step(2);
        words(16'h0000, 16'h0000);
        @(posedge clk_sys);
        packet_open <= 1'b1;
        repeat (12) @(posedge clk_sys);
        packet_open <= 1'b0;
        step(2);
        words(16'h0010, 16'h0010);
        chk16("flush count", 16'd2, 16'(n_flush));
        clr_all();
        @(posedge clk_sys);
        nv_thr <= {16'h0111, 16'h0100, 16'h0040, 16'h0020};
        nv_load <= 1'b1;
        @(posedge clk_sys);
        nv_load <= 1'b0;
        step(1);
        chk_thr({16'h0111, 16'h0100, 16'h0040, 16'h0020});
        @(posedge clk_sys);
        ce <= 1'b0;
        ev <= 5'h04;
        @(posedge clk_sys);
        ev <= 5'h00;
        ce <= 1'b1;
        step(1);
        words(16'h0000, 16'h0000);
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        step(1);
        chk_thr(THR_DEF);
        words(16'h0030, 16'h0030);
        summarize();
    end
endmodule // tas_status_thresholds_tb_top
